// [rtl/tmr_timer16.sv]
// Module: 16-bit timer with rollover flag, sleep counting and capture/compare time base
// Operation
// - The 16-bit counter counts up to ffff and wraps to 0000 on the next count.
// - A wrap from ffff to 0000 sets the rollover interrupt flag.
// - The rollover interrupt asserts only with timer on, rollover, peripheral and global enables set.
// - The rollover flag stays set until software clears it.
// - In sleep the counter runs only as an asynchronous counter from the external source.
// - An overflow in sleep wakes the core, and the interrupt follows only with global enable.
// - The secondary oscillator keeps running in sleep whatever the sync disable bit says.
// - In capture mode a capture event copies the counter into the capture/compare pair.
// - In compare mode equality of counter and compare pair fires an event.
// - A special event trigger from any unit clears both counter bytes.
// - A special event clear does not set the rollover flag.
// - In special event mode the compare pair acts as the counter period.
// - A software write to a counter byte wins over a coincident special event clear.
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module tmr_timer16 (
  // System
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Clock sources and power state
  input  wire logic        ext_clk_i,
  input  wire logic        sleep_i,
  output logic             sosc_run_o,
  // Capture/compare side
  input  wire logic        capture_evt_i,
  input  wire logic        special_trig_i,
  output logic             compare_evt_o,
  // Interrupt and wake
  output logic             irq_o,
  output logic             wake_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tmr_pkg::tmr_ctrl_s   ctrl_q;
  tmr_pkg::tmr_ccmode_e ccmode_q;
  tmr_pkg::tmr_wb_req_s req;
  logic [15:0]          count_q;
  logic [15:0]          count_d;
  logic [15:0]          ccv_q;
  logic [2:0]           status_q;
  logic [2:0]           status_d;
  logic [2:0]           mask_q;
  logic [1:0]           div_q;
  logic                 ext_prev_q;
  logic                 match_prev_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic wr_lane0;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic cnt_write;

  function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign req       = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                       adr: wb_adr_i, dat: wb_dat_i};
  assign wr_en     = req.cyc && req.stb && req.we && ack_q;
  assign wr_lane0  = wr_en && req.sel[0];
  assign wr_cnt_lo = wr_lane0 && hit(req.adr, tmr_pkg::ADR_CNT_LO);
  assign wr_cnt_hi = wr_lane0 && hit(req.adr, tmr_pkg::ADR_CNT_HI);
  assign cnt_write = wr_cnt_lo || wr_cnt_hi;

  // Single wait state; ack drops in the cycle after it is given
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req.cyc && req.stb && !ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // Read data captured on the same edge that raises ack; unmapped reads return zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdat_q <= 32'h0000_0000;
    end else if (req.cyc && req.stb && !ack_q) begin
      case (req.adr)
        tmr_pkg::ADR_CTRL:   rdat_q <= {25'h0, ctrl_q};
        tmr_pkg::ADR_CNT_LO: rdat_q <= {24'h0, count_q[7:0]};
        tmr_pkg::ADR_CNT_HI: rdat_q <= {24'h0, count_q[15:8]};
        tmr_pkg::ADR_STATUS: rdat_q <= {29'h0, status_q};
        tmr_pkg::ADR_MASK:   rdat_q <= {29'h0, mask_q};
        tmr_pkg::ADR_CCV_LO: rdat_q <= {24'h0, ccv_q[7:0]};
        tmr_pkg::ADR_CCV_HI: rdat_q <= {24'h0, ccv_q[15:8]};
        tmr_pkg::ADR_CCMODE: rdat_q <= {30'h0, ccmode_q};
        default:             rdat_q <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Control, mask and mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q   <= tmr_pkg::CTRL_RST;
      mask_q   <= tmr_pkg::FLAGS_RST;
      ccmode_q <= tmr_pkg::CCM_OFF;
    end else if (wr_lane0) begin
      if (hit(req.adr, tmr_pkg::ADR_CTRL)) begin
        ctrl_q <= tmr_pkg::tmr_ctrl_s'(req.dat[6:0]);
      end
      if (hit(req.adr, tmr_pkg::ADR_MASK)) begin
        mask_q <= req.dat[2:0];
      end
      if (hit(req.adr, tmr_pkg::ADR_CCMODE)) begin
        ccmode_q <= tmr_pkg::tmr_ccmode_e'(req.dat[1:0]);
      end
    end
  end

  // Oscillator runs through sleep, independent of sync disable
  assign sosc_run_o = ctrl_q.secondary_osc_enable;

  // ----------------------------------------------------------------
  // Count enable
  // ----------------------------------------------------------------
  logic instr_tick;
  logic ext_edge;
  logic src_tick;
  logic async_ext;
  logic inc_en;

  // Instruction clock: system clock divided by four, halted in sleep
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_q      <= tmr_pkg::DIV_RST;
      ext_prev_q <= 1'b0;
    end else begin
      div_q      <= sleep_i ? tmr_pkg::DIV_RST : div_q + 2'h1;
      ext_prev_q <= ext_clk_i;
    end
  end

  assign instr_tick = (div_q == tmr_pkg::INSTR_DIV) && !sleep_i;
  assign ext_edge   = ext_clk_i && !ext_prev_q;
  assign async_ext  = ctrl_q.timer_clock_select && ctrl_q.sync_disable_bit;
  assign src_tick   = ctrl_q.timer_clock_select ? ext_edge : instr_tick;
  assign inc_en     = ctrl_q.timer_on_bit &&
                      (sleep_i ? (async_ext && ext_edge) : src_tick);

  // ----------------------------------------------------------------
  // Capture/compare
  // ----------------------------------------------------------------
  logic cmp_mode;
  logic match_now;
  logic match_evt;
  logic capt_evt;
  logic seq_clear;

  assign cmp_mode   = (ccmode_q == tmr_pkg::CCM_COMPARE) ||
                      (ccmode_q == tmr_pkg::CCM_SPECIAL);
  assign match_now  = cmp_mode && (count_q == ccv_q);
  assign match_evt  = match_now && !match_prev_q;
  assign capt_evt   = (ccmode_q == tmr_pkg::CCM_CAPTURE) && capture_evt_i;
  // Compare pair becomes the period in special event mode
  assign seq_clear  = special_trig_i ||
                      (match_evt && (ccmode_q == tmr_pkg::CCM_SPECIAL));
  assign compare_evt_o = match_evt;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match_now;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ccv_q <= tmr_pkg::CCV_RST;
    end else if (capt_evt) begin
      ccv_q <= count_q;
    end else if (wr_lane0 && hit(req.adr, tmr_pkg::ADR_CCV_LO)) begin
      ccv_q[7:0] <= req.dat[7:0];
    end else if (wr_lane0 && hit(req.adr, tmr_pkg::ADR_CCV_HI)) begin
      ccv_q[15:8] <= req.dat[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic wrap;

  assign wrap = inc_en && (count_q == tmr_pkg::CNT_MAX) && !seq_clear && !cnt_write;

  always_comb begin
    count_d = count_q;
    if (cnt_write) begin
      if (wr_cnt_lo) begin
        count_d[7:0] = req.dat[7:0];
      end
      if (wr_cnt_hi) begin
        count_d[15:8] = req.dat[7:0];
      end
    end else if (seq_clear) begin
      count_d = tmr_pkg::CNT_RST;
    end else if (inc_en) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= tmr_pkg::CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  logic [2:0] set_vec;
  logic [2:0] clr_vec;
  logic       roll_req;
  logic       other_req;

  assign set_vec = {match_evt, capt_evt, wrap};
  assign clr_vec = (wr_lane0 && hit(req.adr, tmr_pkg::ADR_STATUS)) ? req.dat[2:0] : 3'h0;

  // Set wins over a coincident write-one clear
  always_comb begin
    status_d = (status_q & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= tmr_pkg::FLAGS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Mask bit ST_ROLL and the rollover enable and timer on bit in the control register must all be set
  assign roll_req  = status_q[tmr_pkg::ST_ROLL] && ctrl_q.rollover_irq_enable &&
                     mask_q[tmr_pkg::ST_ROLL] && ctrl_q.timer_on_bit;
  assign other_req = |(status_q[2:1] & mask_q[2:1]);
  assign irq_o  = (roll_req || other_req) && ctrl_q.peripheral_irq_enable &&
                  ctrl_q.global_irq_enable;
  // Wake ignores the global enable
  assign wake_o = sleep_i && (roll_req || other_req) &&
                  ctrl_q.peripheral_irq_enable;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
    wrap |=> count_q == 16'h0000)
    else $error("counter did not wrap to zero");

  AST_ROLL_SET: assert property (@(posedge clock) disable iff (sys_rst)
    wrap |=> status_q[0])
    else $error("rollover flag not set on wrap");

  AST_IRQ_GATE: assert property (@(posedge clock) disable iff (sys_rst)
    (!ctrl_q.timer_on_bit || !ctrl_q.global_irq_enable) && !other_req |-> !irq_o)
    else $error("rollover interrupt without all enables");

  AST_STICKY: assert property (@(posedge clock) disable iff (sys_rst)
    status_q[0] && !clr_vec[0] |=> status_q[0])
    else $error("rollover flag cleared by hardware");

  AST_SLEEP_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    sleep_i && !async_ext && !cnt_write && !seq_clear |=> $stable(count_q))
    else $error("counter advanced in sleep without async mode");

  AST_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    sleep_i && wrap && ctrl_q.rollover_irq_enable && mask_q[0] &&
    ctrl_q.peripheral_irq_enable && $past(sleep_i) ##1 sleep_i |-> wake_o)
    else $error("no wake on overflow in sleep");

  AST_OSC: assert property (@(posedge clock) disable iff (sys_rst)
    sleep_i && ctrl_q.secondary_osc_enable |-> sosc_run_o)
    else $error("secondary oscillator stopped in sleep");

  AST_CAPTURE: assert property (@(posedge clock) disable iff (sys_rst)
    capt_evt |=> ccv_q == $past(count_q))
    else $error("capture did not copy counter");

  AST_COMPARE: assert property (@(posedge clock) disable iff (sys_rst)
    cmp_mode && count_q == ccv_q && !match_prev_q |-> compare_evt_o ##1
    status_q[tmr_pkg::ST_CMP])
    else $error("compare match did not fire");

  AST_TRIG_CLR: assert property (@(posedge clock) disable iff (sys_rst)
    special_trig_i && !cnt_write |=> count_q == 16'h0000)
    else $error("special trigger did not clear counter");

  AST_TRIG_NOFLAG: assert property (@(posedge clock) disable iff (sys_rst)
    seq_clear && !status_q[0] |=> !status_q[0])
    else $error("special trigger set rollover flag");

  AST_WRITE_WINS: assert property (@(posedge clock) disable iff (sys_rst)
    wr_cnt_lo && seq_clear |=> count_q[7:0] == $past(req.dat[7:0]))
    else $error("trigger overrode software write");

  AST_INCR: assert property (@(posedge clock) disable iff (sys_rst)
    inc_en && !cnt_write && !seq_clear && count_q != tmr_pkg::CNT_MAX |=>
    count_q == $past(count_q) + 16'h0001)
    else $error("counter did not advance by one");

  AST_ROLL_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
    status_q[tmr_pkg::ST_ROLL] && mask_q[tmr_pkg::ST_ROLL] && ctrl_q.rollover_irq_enable &&
    ctrl_q.timer_on_bit && ctrl_q.peripheral_irq_enable && ctrl_q.global_irq_enable |-> irq_o)
    else $error("rollover interrupt missing with all enables set");

  AST_WAKE_SLEEP: assert property (@(posedge clock) disable iff (sys_rst)
    !sleep_i |-> !wake_o)
    else $error("wake request outside sleep");

  AST_CAPT_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
    capt_evt |=> status_q[tmr_pkg::ST_CAPT])
    else $error("capture did not set its flag");

  AST_PERIOD: assert property (@(posedge clock) disable iff (sys_rst)
    match_evt && ccmode_q == tmr_pkg::CCM_SPECIAL && !cnt_write |=> count_q == 16'h0000)
    else $error("period match did not restart counter");

  AST_HI_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    wr_cnt_hi |=> count_q[15:8] == $past(req.dat[7:0]))
    else $error("high byte load did not reach counter");

endmodule

// [rtl/tmr_pkg.sv]
// Package: register map, field layout and types of the 16-bit timer block
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_CTRL   = 5'h00;
  localparam logic [4:0] ADR_CNT_LO = 5'h04;
  localparam logic [4:0] ADR_CNT_HI = 5'h08;
  localparam logic [4:0] ADR_STATUS = 5'h0c;
  localparam logic [4:0] ADR_MASK   = 5'h10;
  localparam logic [4:0] ADR_CCV_LO = 5'h14;
  localparam logic [4:0] ADR_CCV_HI = 5'h18;
  localparam logic [4:0] ADR_CCMODE = 5'h1c;

  // ----------------------------------------------------------------
  // Status and mask bit positions
  // ----------------------------------------------------------------
  localparam int ST_ROLL = 0;
  localparam int ST_CAPT = 1;
  localparam int ST_CMP  = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CCV_RST    = 16'h0000;
  localparam logic [2:0]  FLAGS_RST  = 3'h0;
  localparam logic [1:0]  INSTR_DIV  = 2'h3;
  localparam logic [1:0]  DIV_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic rollover_irq_enable;
    logic secondary_osc_enable;
    logic timer_clock_select;
    logic sync_disable_bit;
    logic timer_on_bit;
  } tmr_ctrl_s;

  localparam tmr_ctrl_s CTRL_RST = '0;

  typedef enum logic [1:0] {
    CCM_OFF     = 2'b00,
    CCM_CAPTURE = 2'b01,
    CCM_COMPARE = 2'b10,
    CCM_SPECIAL = 2'b11
  } tmr_ccmode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] dat;
  } tmr_wb_req_s;

endpackage

// [tb/tmr_ccp_model.sv]
// Partner model: capture/compare unit and secondary oscillator
`timescale 1ns/10ps
module tmr_ccp_model (
  // System
  input  wire logic clock,
  input  wire logic sys_rst,
  // Requests from the bench
  input  wire logic fire_trig_i,
  input  wire logic fire_capt_i,
  input  wire logic step_i,
  // Oscillator enable from the timer
  input  wire logic osc_en_i,
  // Toward the timer
  output logic      special_trig_o,
  output logic      capture_evt_o,
  output logic      ext_clk_o
);
  // ------------------------------------------------------------
  // Event pulses, synchronous to the system clock
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      special_trig_o <= 1'b0;
      capture_evt_o  <= 1'b0;
    end else begin
      special_trig_o <= fire_trig_i;
      capture_evt_o  <= fire_capt_i;
    end
  end

  // ------------------------------------------------------------
  // Oscillator free-runs while enabled, sleep or not
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clk_o <= 1'b0;
    end else begin
      ext_clk_o <= osc_en_i ? ~ext_clk_o : step_i;
    end
  end
endmodule

// [tb/tmr_timer16_tb.sv]
// Testbench: 16-bit timer with queue-checked register reads
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tmr_timer16_tb;
  logic        clock, sys_rst, cyc, stb, we, fire_trig, fire_capt;
  logic        step_r, sleep_r, wb_ack_o, sosc_run_o, compare_evt_o;
  logic        irq_o, wake_o, capture_evt, special_trig, ext_clk;
  logic [4:0]  adr;
  logic [31:0] dat, got_exp, wb_dat_o;
  logic [31:0] exp_q[$];
  logic [15:0] v;
  logic [7:0]  n;
  logic [7:0]  pin_q[$];
  logic [7:0]  pin_e;
  int          miscompares, checks_done, cmp_seen, tick, i, m;

  tmr_timer16 DUT (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk),
    .sleep_i(sleep_r), .sosc_run_o(sosc_run_o), .capture_evt_i(capture_evt),
    .special_trig_i(special_trig), .compare_evt_o(compare_evt_o),
    .irq_o(irq_o), .wake_o(wake_o));

  tmr_ccp_model PEER (
    .clock(clock), .sys_rst(sys_rst), .fire_trig_i(fire_trig),
    .fire_capt_i(fire_capt), .step_i(step_r), .osc_en_i(sosc_run_o),
    .special_trig_o(special_trig), .capture_evt_o(capture_evt),
    .ext_clk_o(ext_clk));

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic t);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    fire_trig <= t;
    do begin
      @(posedge clock);
      fire_trig <= 1'b0;
    end while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic t = 1'b0);
    bus(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic t = 1'b0);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, t);
  endtask
  // Pin expectation: kind 0 irq, 1 wake, 2 osc, else compare pulse total
  task automatic pin(input logic [3:0] k, input logic [3:0] e);
    pin_q.push_back({k, e});
  endtask
  // One external clock edge per count
  task automatic step(input int k);
    repeat (k) begin
      @(posedge clock);
      step_r <= 1'b1;
      @(posedge clock);
      step_r <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read checker, compare counter and timeout
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      got_exp = exp_q.pop_front();
      `CHK("read data", got_exp, wb_dat_o)
    end
    if (compare_evt_o === 1'b1)
      cmp_seen++;
    while (pin_q.size() > 0) begin
      pin_e = pin_q.pop_front();
      case (pin_e[7:4])
        4'h0: `CHK("irq", pin_e[0], irq_o)
        4'h1: `CHK("wake", pin_e[0], wake_o)
        4'h2: `CHK("osc run", pin_e[0], sosc_run_o)
        default: `CHK("compare pulses", 32'(pin_e[3:0]), 32'(cmp_seen))
      endcase
    end
    tick++;
    if (tick == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    {sys_rst, cyc, stb, we, fire_trig, fire_capt, step_r, sleep_r} = 8'hff;
    {cyc, stb, we, fire_trig, fire_capt, step_r, sleep_r} = 7'h00;
    adr = 5'h00;
    dat = 32'h0;
    void'($urandom(32'h11c2abef));
    v = 16'($urandom());
    n = 8'(3 + $urandom_range(9));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i++)
      rd(5'(i * 4), 8'h00);
    wr(5'h02, 8'hff);
    rd(5'h02, 8'h00);
    // Rollover, flag and interrupt gating
    wr(tmr_pkg::ADR_MASK, 8'h07);
    wr(tmr_pkg::ADR_CNT_LO, 8'hff);
    wr(tmr_pkg::ADR_CNT_HI, 8'hff);
    wr(tmr_pkg::ADR_STATUS, 8'h07);
    wr(tmr_pkg::ADR_CTRL, 8'h75);
    pin(4'h0, 4'h0);
    step(1);
    pin(4'h0, 4'h1);
    rd(tmr_pkg::ADR_CNT_LO, 8'h00);
    rd(tmr_pkg::ADR_CNT_HI, 8'h00);
    wr(tmr_pkg::ADR_CTRL, 8'h35);
    pin(4'h0, 4'h0);
    step(1);
    rd(tmr_pkg::ADR_STATUS, 8'h01);
    wr(tmr_pkg::ADR_STATUS, 8'h01);
    rd(tmr_pkg::ADR_STATUS, 8'h00);
    // Special trigger clear, and a write that wins over it
    wr(tmr_pkg::ADR_CNT_HI, 8'h3c);
    rd(tmr_pkg::ADR_MASK, 8'h07, 1'b1);
    rd(tmr_pkg::ADR_CNT_HI, 8'h00);
    rd(tmr_pkg::ADR_STATUS, 8'h00);
    wr(tmr_pkg::ADR_CNT_HI, 8'h42);
    wr(tmr_pkg::ADR_CNT_LO, 8'h77, 1'b1);
    rd(tmr_pkg::ADR_CNT_LO, 8'h77);
    rd(tmr_pkg::ADR_CNT_HI, 8'h42);
    // Capture of a random count
    wr(tmr_pkg::ADR_CCMODE, 8'(tmr_pkg::CCM_CAPTURE));
    wr(tmr_pkg::ADR_CNT_LO, v[7:0]);
    wr(tmr_pkg::ADR_CNT_HI, v[15:8]);
    @(posedge clock);
    fire_capt <= 1'b1;
    @(posedge clock);
    fire_capt <= 1'b0;
    repeat (3) @(posedge clock);
    rd(tmr_pkg::ADR_CCV_LO, v[7:0]);
    rd(tmr_pkg::ADR_CCV_HI, v[15:8]);
    rd(tmr_pkg::ADR_STATUS, 8'h02);
    // Compare, then compare with period restart
    for (m = 2; m < 4; m++) begin
      wr(tmr_pkg::ADR_CCMODE, 8'h00);
      wr(tmr_pkg::ADR_CNT_LO, 8'h00);
      wr(tmr_pkg::ADR_CNT_HI, 8'h00);
      wr(tmr_pkg::ADR_CCV_LO, n);
      wr(tmr_pkg::ADR_CCV_HI, 8'h00);
      wr(tmr_pkg::ADR_STATUS, 8'h07);
      wr(tmr_pkg::ADR_CCMODE, 8'(m));
      step(n);
      pin(4'h3, 4'(m - 1));
      rd(tmr_pkg::ADR_CNT_LO, (m == 3) ? 8'h00 : n);
      rd(tmr_pkg::ADR_STATUS, 8'h04);
    end
    // Sleep: counting modes and wake
    wr(tmr_pkg::ADR_CCMODE, 8'h00);
    @(posedge clock);
    sleep_r <= 1'b1;
    wr(tmr_pkg::ADR_CTRL, 8'h01);
    wr(tmr_pkg::ADR_CNT_LO, 8'h55);
    repeat (40) @(posedge clock);
    rd(tmr_pkg::ADR_CNT_LO, 8'h55);
    wr(tmr_pkg::ADR_CTRL, 8'h0d);
    repeat (40) @(posedge clock);
    rd(tmr_pkg::ADR_CNT_LO, 8'h55);
    pin(4'h2, 4'h1);
    wr(tmr_pkg::ADR_STATUS, 8'h07);
    wr(tmr_pkg::ADR_CTRL, 8'h3f);
    pin(4'h1, 4'h0);
    wr(tmr_pkg::ADR_CNT_HI, 8'hff);
    wr(tmr_pkg::ADR_CNT_LO, 8'hfe);
    for (i = 0; i < 20 && wake_o !== 1'b1; i++)
      @(posedge clock);
    pin(4'h1, 4'h1);
    pin(4'h0, 4'h0);
    wr(tmr_pkg::ADR_CTRL, 8'h7f);
    pin(4'h0, 4'h1);
    @(posedge clock);
    sleep_r <= 1'b0;
    @(negedge clock);
    pin(4'h1, 4'h0);
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule
